// ---- src/mrs_dp_if.sv ----
`timescale 1ns/1ps
interface mrs_dp_if;
   logic [7:0] opa;
   logic [7:0] opb;
   logic cin;
   logic use_cin;
   mrs_pkg::mrs_rot_e rot_sel;
   logic [2:0] bit_sel;
   logic [7:0] rot_res;
   logic rot_cout;
   logic [7:0] sub_res;
   logic sub_c;
   logic sub_ac;
   logic sub_ov;

   modport core (
      output opa, opb, cin, use_cin, rot_sel, bit_sel,
      input rot_res, rot_cout, sub_res, sub_c, sub_ac, sub_ov
   );
   modport rot (
      input opb, cin, rot_sel, bit_sel,
      output rot_res, rot_cout
   );
   modport sub (
      input opa, opb, cin, use_cin,
      output sub_res, sub_c, sub_ac, sub_ov
   );
endinterface : mrs_dp_if

// ---- src/mrs_exec_core.sv ----
`timescale 1ns/1ps
// How it works
// RQ1: rotate memory byte left, bit 7 into bit 0, flags kept.
// RQ2: rotate left through carry; old carry to bit 0, bit 7 to carry.
// RQ3: rotate memory byte right, bit 0 into bit 7, flags kept.
// RQ4: rotate right through carry; old carry to bit 7, bit 0 to carry.
// RQ5: work forms write work register only, memory untouched, same flags.
// RQ6: subtract with borrow: work minus byte minus inverted carry, four flags.
// RQ7: carry cleared on negative result, set on zero or positive.
// RQ8: plain subtract of byte or immediate, to work or memory, four flags.
// RQ9: decrement, write memory or work, skip on zero, no flags.
// RQ10: increment, write memory or work, skip on zero, no flags.
// RQ11: skip instructions last two cycles; dummy slot when skip taken.
// RQ12: skip next when selected bit is one, nothing modified.
// RQ13: skip next when selected bit is zero, no flags.
// RQ14: byte written back unchanged, skip when zero, no flags.
// RQ15: byte copied to work register, skip when zero, no flags.
// RQ16: fill byte with ones or set one bit, no flags.
// RQ17: swap nibbles in place or into work register, no flags.
// RQ18: table read by high and low pointer, low byte to memory.
// RQ19: last page table read by low pointer only, high byte held.
// RQ20: xor with byte or immediate, to work or memory, zero flag only.
// RQ21: zero flag means zero result; usual nibble borrow and overflow.
module mrs_exec_core (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic op_valid_in,
   input wire mrs_pkg::mrs_op_e op_code_in,
   input wire logic [2:0] bit_sel_in,
   input wire logic [7:0] imm_in,
   input wire logic [7:0] mem_rd_data_in,
   input wire logic [7:0] table_low_pointer_in,
   input wire logic [3:0] table_high_pointer_in,
   input wire logic has_high_pointer_in,
   input wire logic [3:0] cur_page_in,
   input wire logic [15:0] prog_data_in,
   output logic op_ready_out,
   output logic done_out,
   output logic skip_taken_out,
   output logic dummy_slot_out,
   output logic [7:0] work_register_out,
   output logic borrow_out_flag_out,
   output logic null_result_flag_out,
   output logic nibble_borrow_flag_out,
   output logic signed_wrap_flag_out,
   output logic [7:0] table_high_byte_reg_out,
   output logic mem_wr_en_out,
   output logic [7:0] mem_wr_data_out,
   output logic prog_rd_en_out,
   output logic [11:0] prog_addr_out
);

   mrs_pkg::mrs_state_s cur_ff;
   mrs_pkg::mrs_state_s nxt_st;
   mrs_dp_if dp ();

   logic [7:0] inc_val;
   logic [7:0] dec_val;
   logic [7:0] xor_val;
   logic [7:0] sel_bit;
   logic use_imm;

   mrs_rotate_unit u_rot (
      .dp (dp.rot)
   );

   mrs_sub_unit u_sub (
      .dp (dp.sub)
   );

   // immediate forms take their operand from imm_in
   assign use_imm = (op_code_in == mrs_pkg::op_sub_i) ||
                    (op_code_in == mrs_pkg::op_xor_i);

   assign dp.opa = cur_ff.work;
   assign dp.opb = use_imm ? imm_in : mem_rd_data_in;
   assign dp.cin = cur_ff.c;
   assign dp.bit_sel = bit_sel_in;
   // RQ6: only the borrow forms feed the carry in
   assign dp.use_cin = (op_code_in == mrs_pkg::op_subb_w) ||
                       (op_code_in == mrs_pkg::op_subb_m);

   assign inc_val = mem_rd_data_in + mrs_pkg::BYTE_ONE;
   assign dec_val = mem_rd_data_in - mrs_pkg::BYTE_ONE;
   assign xor_val = cur_ff.work ^ dp.opb;
   assign sel_bit = mem_rd_data_in & mrs_pkg::bit_mask(bit_sel_in);

   always_comb
   begin
      case (op_code_in)
         mrs_pkg::op_rol_m,
         mrs_pkg::op_rol_w: dp.rot_sel = mrs_pkg::rot_left;
         mrs_pkg::op_rolc_m,
         mrs_pkg::op_rolc_w: dp.rot_sel = mrs_pkg::rot_left_c;
         mrs_pkg::op_ror_m,
         mrs_pkg::op_ror_w: dp.rot_sel = mrs_pkg::rot_right;
         mrs_pkg::op_rorc_m,
         mrs_pkg::op_rorc_w: dp.rot_sel = mrs_pkg::rot_right_c;
         mrs_pkg::op_swap_m,
         mrs_pkg::op_swap_w: dp.rot_sel = mrs_pkg::rot_swap;
         mrs_pkg::op_fill_m: dp.rot_sel = mrs_pkg::rot_fill;
         mrs_pkg::op_bit_set_m: dp.rot_sel = mrs_pkg::rot_bit_set;
         default: dp.rot_sel = mrs_pkg::rot_pass;
      endcase
   end

   always_comb
   begin
      nxt_st = cur_ff;
      nxt_st.done = 1'b0;
      nxt_st.wr_en = 1'b0;
      nxt_st.rd_en = 1'b0;
      nxt_st.dummy = 1'b0;
      case (cur_ff.st)
         mrs_pkg::st_idle:
         begin
            if (op_valid_in)
            begin
               nxt_st.done = 1'b1;
               nxt_st.skip = 1'b0;
               case (op_code_in)
                  // RQ1: memory rotate, flags untouched
                  mrs_pkg::op_rol_m,
                  mrs_pkg::op_ror_m:
                  begin
                     nxt_st.wr_en = 1'b1;
                     nxt_st.wr_data = dp.rot_res;
                  end
                  // RQ2: carry takes the bit shifted out
                  mrs_pkg::op_rolc_m,
                  mrs_pkg::op_rorc_m:
                  begin
                     nxt_st.wr_en = 1'b1;
                     nxt_st.wr_data = dp.rot_res;
                     nxt_st.c = dp.rot_cout;
                  end
                  // RQ5: work forms leave memory alone
                  mrs_pkg::op_rol_w,
                  mrs_pkg::op_ror_w:
                  begin
                     nxt_st.work = dp.rot_res;
                  end
                  // RQ5: work forms with carry
                  mrs_pkg::op_rolc_w,
                  mrs_pkg::op_rorc_w:
                  begin
                     nxt_st.work = dp.rot_res;
                     nxt_st.c = dp.rot_cout;
                  end
                  // RQ8: subtract into work register
                  mrs_pkg::op_subb_w,
                  mrs_pkg::op_sub_w,
                  mrs_pkg::op_sub_i:
                  begin
                     nxt_st.work = dp.sub_res;
                     nxt_st.c = dp.sub_c;
                     nxt_st.ac = dp.sub_ac;
                     nxt_st.ov = dp.sub_ov;
                     nxt_st.z = (dp.sub_res == mrs_pkg::BYTE_ZERO);
                  end
                  // RQ6: subtract back into memory
                  mrs_pkg::op_subb_m,
                  mrs_pkg::op_sub_m:
                  begin
                     nxt_st.wr_en = 1'b1;
                     nxt_st.wr_data = dp.sub_res;
                     nxt_st.c = dp.sub_c;
                     nxt_st.ac = dp.sub_ac;
                     nxt_st.ov = dp.sub_ov;
                     nxt_st.z = (dp.sub_res == mrs_pkg::BYTE_ZERO);
                  end
                  // RQ9: decrement to memory, skip on zero
                  mrs_pkg::op_decsk_m:
                  begin
                     nxt_st.wr_en = 1'b1;
                     nxt_st.wr_data = dec_val;
                     nxt_st.skip = (dec_val == mrs_pkg::BYTE_ZERO);
                  end
                  // RQ9: decrement to work only
                  mrs_pkg::op_decsk_w:
                  begin
                     nxt_st.work = dec_val;
                     nxt_st.skip = (dec_val == mrs_pkg::BYTE_ZERO);
                  end
                  // RQ10: increment to memory, skip on zero
                  mrs_pkg::op_incsk_m:
                  begin
                     nxt_st.wr_en = 1'b1;
                     nxt_st.wr_data = inc_val;
                     nxt_st.skip = (inc_val == mrs_pkg::BYTE_ZERO);
                  end
                  // RQ10: increment to work only
                  mrs_pkg::op_incsk_w:
                  begin
                     nxt_st.work = inc_val;
                     nxt_st.skip = (inc_val == mrs_pkg::BYTE_ZERO);
                  end
                  // RQ12: skip when the bit is one
                  mrs_pkg::op_bitone_sk:
                  begin
                     nxt_st.skip = |sel_bit;
                  end
                  // RQ13: skip when the bit is zero
                  mrs_pkg::op_bitnil_sk:
                  begin
                     nxt_st.skip = ~|sel_bit;
                  end
                  // RQ14: same value written back
                  mrs_pkg::op_nil_sk_m:
                  begin
                     nxt_st.wr_en = 1'b1;
                     nxt_st.wr_data = mem_rd_data_in;
                     nxt_st.skip = (mem_rd_data_in == mrs_pkg::BYTE_ZERO);
                  end
                  // RQ15: copy into work, test it
                  mrs_pkg::op_nil_sk_w:
                  begin
                     nxt_st.work = mem_rd_data_in;
                     nxt_st.skip = (mem_rd_data_in == mrs_pkg::BYTE_ZERO);
                  end
                  // RQ16: fill or single bit set
                  mrs_pkg::op_fill_m,
                  mrs_pkg::op_bit_set_m:
                  begin
                     nxt_st.wr_en = 1'b1;
                     nxt_st.wr_data = dp.rot_res;
                  end
                  // RQ17: swap in place
                  mrs_pkg::op_swap_m:
                  begin
                     nxt_st.wr_en = 1'b1;
                     nxt_st.wr_data = dp.rot_res;
                  end
                  // RQ17: swap into work
                  mrs_pkg::op_swap_w:
                  begin
                     nxt_st.work = dp.rot_res;
                  end
                  // RQ18: pointer pair, or current page
                  mrs_pkg::op_tbl_cur:
                  begin
                     nxt_st.done = 1'b0;
                     nxt_st.rd_en = 1'b1;
                     nxt_st.st = mrs_pkg::st_tbl_req;
                     if (has_high_pointer_in)
                     begin
                        nxt_st.paddr = {table_high_pointer_in, table_low_pointer_in};
                     end
                     else
                     begin
                        nxt_st.paddr = {cur_page_in, table_low_pointer_in};
                     end
                  end
                  // RQ19: fixed final page
                  mrs_pkg::op_tbl_last:
                  begin
                     nxt_st.done = 1'b0;
                     nxt_st.rd_en = 1'b1;
                     nxt_st.st = mrs_pkg::st_tbl_req;
                     nxt_st.paddr = {mrs_pkg::LAST_PAGE, table_low_pointer_in};
                  end
                  // RQ20: xor into work, zero flag only
                  mrs_pkg::op_xor_w,
                  mrs_pkg::op_xor_i:
                  begin
                     nxt_st.work = xor_val;
                     nxt_st.z = (xor_val == mrs_pkg::BYTE_ZERO);
                  end
                  // RQ20: xor into memory
                  mrs_pkg::op_xor_m:
                  begin
                     nxt_st.wr_en = 1'b1;
                     nxt_st.wr_data = xor_val;
                     nxt_st.z = (xor_val == mrs_pkg::BYTE_ZERO);
                  end
                  // unused codes complete with no effect
                  default:
                  begin
                     nxt_st.done = 1'b1;
                  end
               endcase
               // RQ11: every skip op takes a second cycle
               case (op_code_in)
                  mrs_pkg::op_decsk_m,
                  mrs_pkg::op_decsk_w,
                  mrs_pkg::op_incsk_m,
                  mrs_pkg::op_incsk_w,
                  mrs_pkg::op_bitone_sk,
                  mrs_pkg::op_bitnil_sk,
                  mrs_pkg::op_nil_sk_m,
                  mrs_pkg::op_nil_sk_w:
                  begin
                     nxt_st.done = 1'b0;
                     nxt_st.st = mrs_pkg::st_second;
                     nxt_st.dummy = nxt_st.skip;
                  end
                  default:
                  begin
                     nxt_st.st = nxt_st.st;
                  end
               endcase
            end
         end
         // RQ11: second cycle ends the op, dummy slot or not
         mrs_pkg::st_second:
         begin
            nxt_st.done = 1'b1;
            nxt_st.st = mrs_pkg::st_idle;
         end
         // program memory samples the strobe here
         mrs_pkg::st_tbl_req:
         begin
            nxt_st.st = mrs_pkg::st_tbl_cap;
         end
         // RQ18: low byte to memory, high byte held
         mrs_pkg::st_tbl_cap:
         begin
            nxt_st.wr_en = 1'b1;
            nxt_st.wr_data = prog_data_in[mrs_pkg::TBL_LOW_LSB +: mrs_pkg::DATA_W];
            nxt_st.tbh = prog_data_in[mrs_pkg::TBL_HIGH_LSB +: mrs_pkg::DATA_W];
            nxt_st.done = 1'b1;
            nxt_st.st = mrs_pkg::st_idle;
         end
         default:
         begin
            nxt_st.st = mrs_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         cur_ff.st <= mrs_pkg::st_idle;
         cur_ff.work <= mrs_pkg::WORK_RST;
         cur_ff.c <= mrs_pkg::FLAG_RST;
         cur_ff.z <= mrs_pkg::FLAG_RST;
         cur_ff.ac <= mrs_pkg::FLAG_RST;
         cur_ff.ov <= mrs_pkg::FLAG_RST;
         cur_ff.tbh <= mrs_pkg::TBH_RST;
         cur_ff.wr_en <= 1'b0;
         cur_ff.wr_data <= mrs_pkg::BYTE_ZERO;
         cur_ff.rd_en <= 1'b0;
         cur_ff.paddr <= mrs_pkg::PADDR_RST;
         cur_ff.done <= 1'b0;
         cur_ff.skip <= 1'b0;
         cur_ff.dummy <= 1'b0;
      end
      else
      begin
         cur_ff <= nxt_st;
      end
   end

   // handshake is combinational; a new op may follow every done
   assign op_ready_out = (cur_ff.st == mrs_pkg::st_idle);
   assign done_out = cur_ff.done;
   assign skip_taken_out = cur_ff.skip;
   assign dummy_slot_out = cur_ff.dummy;
   assign work_register_out = cur_ff.work;
   assign borrow_out_flag_out = cur_ff.c;
   assign null_result_flag_out = cur_ff.z;
   assign nibble_borrow_flag_out = cur_ff.ac;
   assign signed_wrap_flag_out = cur_ff.ov;
   assign table_high_byte_reg_out = cur_ff.tbh;
   assign mem_wr_en_out = cur_ff.wr_en;
   assign mem_wr_data_out = cur_ff.wr_data;
   assign prog_rd_en_out = cur_ff.rd_en;
   assign prog_addr_out = cur_ff.paddr;

endmodule : mrs_exec_core

// ---- src/mrs_pkg.sv ----
package mrs_pkg;

   localparam int DATA_W = 8;
   localparam int PAGE_W = 4;
   localparam int PROG_AW = 12;
   localparam int PROG_DW = 16;

   localparam logic [7:0] WORK_RST = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [7:0] ALL_ONES = 8'hFF;
   localparam logic [7:0] TBH_RST = 8'h00;
   localparam logic FLAG_RST = 1'b0;
   localparam logic [PAGE_W-1:0] LAST_PAGE = 4'hF;
   localparam logic [PROG_AW-1:0] PADDR_RST = 12'h000;
   localparam int TBL_LOW_LSB = 0;
   localparam int TBL_HIGH_LSB = 8;

   typedef enum logic [4:0] {
      op_rol_m = 5'h00,
      op_rol_w = 5'h01,
      op_rolc_m = 5'h02,
      op_rolc_w = 5'h03,
      op_ror_m = 5'h04,
      op_ror_w = 5'h05,
      op_rorc_m = 5'h06,
      op_rorc_w = 5'h07,
      op_subb_w = 5'h08,
      op_subb_m = 5'h09,
      op_sub_w = 5'h0A,
      op_sub_m = 5'h0B,
      op_sub_i = 5'h0C,
      op_decsk_m = 5'h0D,
      op_decsk_w = 5'h0E,
      op_incsk_m = 5'h0F,
      op_incsk_w = 5'h10,
      op_bitone_sk = 5'h11,
      op_bitnil_sk = 5'h12,
      op_nil_sk_m = 5'h13,
      op_nil_sk_w = 5'h14,
      op_fill_m = 5'h15,
      op_bit_set_m = 5'h16,
      op_swap_m = 5'h17,
      op_swap_w = 5'h18,
      op_tbl_cur = 5'h19,
      op_tbl_last = 5'h1A,
      op_xor_w = 5'h1B,
      op_xor_m = 5'h1C,
      op_xor_i = 5'h1D
   } mrs_op_e;

   typedef enum logic [2:0] {
      rot_left = 3'b000,
      rot_left_c = 3'b001,
      rot_right = 3'b010,
      rot_right_c = 3'b011,
      rot_swap = 3'b100,
      rot_fill = 3'b101,
      rot_bit_set = 3'b110,
      rot_pass = 3'b111
   } mrs_rot_e;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_second = 2'b01,
      st_tbl_req = 2'b10,
      st_tbl_cap = 2'b11
   } mrs_state_e;

   typedef struct packed {
      mrs_state_e st;
      logic [7:0] work;
      logic c;
      logic z;
      logic ac;
      logic ov;
      logic [7:0] tbh;
      logic wr_en;
      logic [7:0] wr_data;
      logic rd_en;
      logic [PROG_AW-1:0] paddr;
      logic done;
      logic skip;
      logic dummy;
   } mrs_state_s;

   function automatic logic [7:0] bit_mask(input logic [2:0] sel);
      bit_mask = BYTE_ONE << sel;
   endfunction : bit_mask

endpackage : mrs_pkg

// ---- src/mrs_rotate_unit.sv ----
`timescale 1ns/1ps
module mrs_rotate_unit (
   mrs_dp_if.rot dp
);
   always_comb
   begin
      dp.rot_cout = dp.cin;
      case (dp.rot_sel)
         // RQ1: plain left rotate
         mrs_pkg::rot_left: dp.rot_res = {dp.opb[6:0], dp.opb[7]};
         mrs_pkg::rot_left_c:
         begin
            // RQ2: carry in low, bit 7 out
            dp.rot_res = {dp.opb[6:0], dp.cin};
            dp.rot_cout = dp.opb[7];
         end
         // RQ3: plain right rotate
         mrs_pkg::rot_right: dp.rot_res = {dp.opb[0], dp.opb[7:1]};
         mrs_pkg::rot_right_c:
         begin
            // RQ4: carry in high, bit 0 out
            dp.rot_res = {dp.cin, dp.opb[7:1]};
            dp.rot_cout = dp.opb[0];
         end
         // RQ17: nibble exchange
         mrs_pkg::rot_swap: dp.rot_res = {dp.opb[3:0], dp.opb[7:4]};
         // RQ16: whole byte to ones
         mrs_pkg::rot_fill: dp.rot_res = mrs_pkg::ALL_ONES;
         // RQ16: single bit forced
         mrs_pkg::rot_bit_set: dp.rot_res = dp.opb | mrs_pkg::bit_mask(dp.bit_sel);
         default: dp.rot_res = dp.opb;
      endcase
   end
endmodule : mrs_rotate_unit

// ---- src/mrs_sub_unit.sv ----
`timescale 1ns/1ps
module mrs_sub_unit (
   mrs_dp_if.sub dp
);
   logic borrow;
   logic [8:0] full;
   logic [4:0] low;

   // RQ6: borrow is the inverted carry
   assign borrow = dp.use_cin & ~dp.cin;
   assign full = {1'b0, dp.opa} - {1'b0, dp.opb} - {8'h00, borrow};
   assign low = {1'b0, dp.opa[3:0]} - {1'b0, dp.opb[3:0]} - {4'h0, borrow};
   assign dp.sub_res = full[7:0];
   // RQ7: set when no borrow out
   assign dp.sub_c = ~full[8];
   // RQ21: nibble and overflow flags
   assign dp.sub_ac = ~low[4];
   assign dp.sub_ov = (dp.opa[7] ^ dp.opb[7]) & (full[7] ^ dp.opa[7]);
endmodule : mrs_sub_unit

// ---- test/mrs_exec_core_props.sv ----
`timescale 1ns/1ps
module mrs_exec_core_props (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic op_valid_in,
   input wire mrs_pkg::mrs_op_e op_code_in,
   input wire logic [7:0] mem_rd_data_in,
   input wire logic op_ready_out,
   input wire logic done_out,
   input wire logic skip_taken_out,
   input wire logic dummy_slot_out,
   input wire logic [7:0] work_register_out,
   input wire logic borrow_out_flag_out,
   input wire logic null_result_flag_out,
   input wire logic mem_wr_en_out,
   input wire logic [7:0] mem_wr_data_out,
   input wire logic prog_rd_en_out
);
   logic [7:0] m_ff;
   logic [7:0] w_ff;
   logic c_ff;
   logic acc;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   assign acc = op_valid_in && op_ready_out;
   // operands as seen at the accepting edge
   always_ff @(posedge clk_sys_in)
   begin
      m_ff <= mem_rd_data_in;
      w_ff <= work_register_out;
      c_ff <= borrow_out_flag_out;
   end
   sequence take(mrs_pkg::mrs_op_e o);
      acc && op_code_in == o;
   endsequence
   sequence skip_tail;
      !op_ready_out ##1 (done_out && op_ready_out);
   endsequence
   sequence tbl_tail;
      prog_rd_en_out && !op_ready_out ##1 !op_ready_out ##1 (done_out && mem_wr_en_out);
   endsequence
   a_rot_left_mem: assert property (take(mrs_pkg::op_rol_m) |=> mem_wr_en_out
      && mem_wr_data_out == {m_ff[6:0], m_ff[7]} && borrow_out_flag_out == c_ff)
      else $error("rotate left result wrong");
   a_rotc_left_work: assert property (take(mrs_pkg::op_rolc_w) |=> !mem_wr_en_out
      && work_register_out == {m_ff[6:0], c_ff} && borrow_out_flag_out == m_ff[7])
      else $error("rotate left through carry wrong");
   a_rot_right_mem: assert property (take(mrs_pkg::op_ror_m) |=>
      mem_wr_data_out == {m_ff[0], m_ff[7:1]} && borrow_out_flag_out == c_ff)
      else $error("rotate right result wrong");
   a_rotc_right_mem: assert property (take(mrs_pkg::op_rorc_m) |=>
      mem_wr_data_out == {c_ff, m_ff[7:1]} && borrow_out_flag_out == m_ff[0])
      else $error("rotate right through carry wrong");
   a_sub_carry_sense: assert property (take(mrs_pkg::op_sub_w) |=>
      borrow_out_flag_out == (w_ff >= m_ff) && work_register_out == w_ff - m_ff)
      else $error("subtract carry wrong");
   a_skip_two_cycles: assert property (acc && op_code_in inside
      {[mrs_pkg::op_decsk_m:mrs_pkg::op_nil_sk_w]} |=> skip_tail)
      else $error("skip op length wrong");
   a_dummy_needs_skip: assert property (dummy_slot_out |-> skip_taken_out && !op_ready_out)
      else $error("dummy slot without skip");
   a_dec_skip_zero: assert property (take(mrs_pkg::op_decsk_m) |=> mem_wr_en_out
      && mem_wr_data_out == m_ff - 8'h01 && skip_taken_out == (m_ff == 8'h01))
      else $error("decrement skip wrong");
   a_fill_all_ones: assert property (take(mrs_pkg::op_fill_m) |=>
      mem_wr_en_out && mem_wr_data_out == 8'hFF && borrow_out_flag_out == c_ff)
      else $error("fill result wrong");
   a_table_read_walk: assert property (acc && op_code_in inside
      {mrs_pkg::op_tbl_cur, mrs_pkg::op_tbl_last} |=> tbl_tail)
      else $error("table read sequence wrong");
   a_xor_zero_flag: assert property (take(mrs_pkg::op_xor_w) |=>
      work_register_out == (w_ff ^ m_ff) && null_result_flag_out == (w_ff == m_ff))
      else $error("xor result wrong");
endmodule : mrs_exec_core_props

bind mrs_exec_core mrs_exec_core_props u_props (.clk_sys_in, .rst_in, .op_valid_in,
   .op_code_in, .mem_rd_data_in, .op_ready_out, .done_out, .skip_taken_out,
   .dummy_slot_out, .work_register_out, .borrow_out_flag_out, .null_result_flag_out,
   .mem_wr_en_out, .mem_wr_data_out, .prog_rd_en_out);

// ---- test/mrs_exec_core_tb.sv ----
`timescale 1ns/1ps
module mrs_exec_core_tb;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic op_valid_in = 1'b0;
   mrs_pkg::mrs_op_e op_code_in = mrs_pkg::op_rol_m;
   logic [2:0] bit_sel_in = 3'h0;
   logic [7:0] imm_in = 8'h00;
   logic [7:0] mem_rd_data_in = 8'h00;
   logic [7:0] table_low_pointer_in = 8'h00;
   logic [3:0] table_high_pointer_in = 4'h0;
   logic has_high_pointer_in = 1'b0;
   logic [3:0] cur_page_in = 4'h0;
   logic [15:0] prog_data_in = 16'h0000;
   logic op_ready_out, done_out, skip_taken_out, dummy_slot_out, borrow_out_flag_out;
   logic null_result_flag_out, nibble_borrow_flag_out, signed_wrap_flag_out;
   logic mem_wr_en_out, prog_rd_en_out;
   logic [7:0] work_register_out, table_high_byte_reg_out, mem_wr_data_out;
   logic [11:0] prog_addr_out, ea, ga;
   logic [7:0] w, tbh, r, gwd;
   logic [15:0] pw;
   logic c, z, ac, ov, sk, wr, wk, gwr, gdm;
   logic [7:0] vals [5] = '{8'h00, 8'h01, 8'h80, 8'hFF, 8'h7F};
   int cyc, n, fail_count, checked;

   mrs_exec_core u_dut (.clk_sys_in, .rst_in, .op_valid_in, .op_code_in, .bit_sel_in,
      .imm_in, .mem_rd_data_in, .table_low_pointer_in, .table_high_pointer_in,
      .has_high_pointer_in, .cur_page_in, .prog_data_in, .op_ready_out, .done_out,
      .skip_taken_out, .dummy_slot_out, .work_register_out, .borrow_out_flag_out,
      .null_result_flag_out, .nibble_borrow_flag_out, .signed_wrap_flag_out,
      .table_high_byte_reg_out, .mem_wr_en_out, .mem_wr_data_out, .prog_rd_en_out,
      .prog_addr_out);

   initial forever #2 clk_sys_in = ~clk_sys_in;

   function automatic logic [15:0] pword(input logic [11:0] a);
      pword = {a[11:4] ^ 8'hC3, a[7:0] + 8'h11};
   endfunction : pword

   // program memory answers one cycle late, garbage otherwise
   always @(posedge clk_sys_in)
      prog_data_in <= (prog_rd_en_out === 1'b1) ? pword(prog_addr_out) : ~prog_data_in;

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check

   task final_report;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report

   task automatic run(input int i, input logic [7:0] m);
      logic [4:0] o;
      logic [8:0] d;
      logic [4:0] h;
      logic bi;
      o = i[4:0];
      op_code_in <= mrs_pkg::mrs_op_e'(o);
      mem_rd_data_in <= m;
      op_valid_in <= 1'b1;
      @(posedge clk_sys_in);
      op_valid_in <= 1'b0;
      // operand only valid with the request
      mem_rd_data_in <= ~m;
      if (o == 5'h0C || o == 5'h1D)
         m = imm_in;
      r = m;
      cyc = 1;
      sk = 1'b0;
      case (o)
         5'h00, 5'h01: r = {m[6:0], m[7]};
         5'h02, 5'h03: begin r = {m[6:0], c}; c = m[7]; end
         5'h04, 5'h05: r = {m[0], m[7:1]};
         5'h06, 5'h07: begin r = {c, m[7:1]}; c = m[0]; end
         5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C:
         begin
            bi = (o == 5'h08 || o == 5'h09) && !c;
            d = {1'b0, w} - {1'b0, m} - bi;
            h = {1'b0, w[3:0]} - {1'b0, m[3:0]} - bi;
            r = d[7:0];
            c = !d[8];
            ac = !h[4];
            z = r == 8'h00;
            ov = (w[7] ^ m[7]) & (w[7] ^ r[7]);
         end
         5'h0D, 5'h0E: r = m - 8'h01;
         5'h0F, 5'h10: r = m + 8'h01;
         5'h11: sk = m[bit_sel_in];
         5'h12: sk = !m[bit_sel_in];
         5'h15: r = 8'hFF;
         5'h16: r = m | (8'h01 << bit_sel_in);
         5'h17, 5'h18: r = {m[3:0], m[7:4]};
         5'h1B, 5'h1C, 5'h1D: begin r = w ^ m; z = r == 8'h00; end
         5'h19, 5'h1A:
         begin
            ea = {o == 5'h1A ? 4'hF : has_high_pointer_in ? table_high_pointer_in
               : cur_page_in, table_low_pointer_in};
            pw = pword(ea);
            r = pw[7:0];
            tbh = pw[15:8];
            cyc = 3;
         end
         default: ;
      endcase
      if (o inside {[5'h0D:5'h14]})
         cyc = 2;
      if (o inside {[5'h0D:5'h10], 5'h13, 5'h14})
         sk = r == 8'h00;
      wr = o inside {5'h00, 5'h02, 5'h04, 5'h06, 5'h09, 5'h0B, 5'h0D, 5'h0F, 5'h13, 5'h15,
         5'h16, 5'h17, 5'h19, 5'h1A, 5'h1C};
      wk = o inside {5'h01, 5'h03, 5'h05, 5'h07, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h14,
         5'h18, 5'h1B, 5'h1D};
      if (wk)
         w = r;
      gwr = 1'b0;
      gdm = 1'b0;
      n = 0;
      do
      begin
         @(negedge clk_sys_in);
         n++;
         if (mem_wr_en_out === 1'b1)
         begin
            gwr = 1'b1;
            gwd = mem_wr_data_out;
         end
         if (dummy_slot_out === 1'b1)
            gdm = 1'b1;
         if (prog_rd_en_out === 1'b1)
            ga = prog_addr_out;
      end
      while (done_out !== 1'b1 && n < 8);
      check(n[15:0], cyc[15:0]);
      check(gdm, sk);
      check(skip_taken_out, sk);
      check(gwr, wr);
      if (wr)
         check(gwd, r);
      check(work_register_out, w);
      check({borrow_out_flag_out, null_result_flag_out, nibble_borrow_flag_out,
         signed_wrap_flag_out}, {c, z, ac, ov});
      check(table_high_byte_reg_out, tbh);
      if (cyc == 3)
         check(ga, ea);
      @(posedge clk_sys_in);
   endtask : run

   initial
   begin
      fail_count = 0;
      checked = 0;
      {w, tbh, c, z, ac, ov} = '0;
      repeat (6) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(negedge clk_sys_in);
      check({op_ready_out, done_out, skip_taken_out, mem_wr_en_out, prog_rd_en_out,
         work_register_out}, {5'h10, 8'h00});
      @(posedge clk_sys_in);
      // every code, including the two unused ones, over boundary operands
      for (int j = 0; j < 5; j++)
         for (int i = 0; i < 32; i++)
         begin
            bit_sel_in <= j[2:0] + i[2:0];
            imm_in <= vals[(i + j) % 5];
            table_low_pointer_in <= vals[j] + i[7:0];
            table_high_pointer_in <= i[3:0];
            has_high_pointer_in <= j[0];
            cur_page_in <= ~i[3:0];
            run(i, vals[j]);
         end
      final_report();
   end

   // whole sequence needs about 400 cycles
   initial
   begin
      repeat (5000) @(posedge clk_sys_in);
      fail_count++;
      final_report();
   end
endmodule : mrs_exec_core_tb
